// *** verilog/cdec_pkg.sv ***
// Constants and types for the depth-expansion chain logic
`default_nettype none
package cdec_pkg;
	localparam int          CDEC_WORD_W     = 16;
	localparam logic [15:0] CDEC_DS_GLOBAL  = 16'hFFFF;
	localparam logic [15:0] CDEC_DS_RESET   = 16'hFFFF;
	localparam logic [15:0] CDEC_SLOT_RESET = 16'h0000;
	localparam logic        CDEC_CMPEN_RESET = 1'b1;
	localparam int          CDEC_SYNC_STAGES = 2;

	// Kind of access taken at the start of a cycle
	typedef enum logic [1:0] {
		CDEC_CMD_WR  = 2'b00,
		CDEC_DATA_WR = 2'b01,
		CDEC_CMD_RD  = 2'b10,
		CDEC_DATA_RD = 2'b11
	} cdec_cycle_t;

	// Decoded target of a command-write cycle
	typedef enum logic [2:0] {
		CDEC_OP_NONE    = 3'b000,
		CDEC_OP_WR_DS   = 3'b001,
		CDEC_OP_WR_SLOT = 3'b010,
		CDEC_OP_SETFULL = 3'b011,
		CDEC_OP_SWRESET = 3'b100
	} cdec_op_t;
endpackage
`default_nettype wire

// *** verilog/cdec_sync.sv ***
// Two-flop synchroniser for a bundle of pin inputs
`default_nettype none
module cdec_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Asynchronous in, synchronised out
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] stage1_reg;

	// First stage read only by the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1_reg <= '0;
			syncOut    <= '0;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

// *** verilog/cdec_chain.sv ***
// Match and full flag daisy-chain, compare-enable capture and device selection
// What this block does
// - Match flag out low when chain input low or enabled local match.
// - Chain input low forces match flag low regardless of local match.
// - Broadcast status read answered only by device with chain high and match.
// - Broadcast highest-match data access serviced only by chain-high matching device.
// - Low match flag at chain end means a match somewhere.
// - Compare enable high at strobe fall forces match flag high.
// - Compare enable low lets match flag follow chain, enable, local match.
// - Captured compare enable holds until recaptured at a later cycle start.
// - Full in low and space free accepts next-free writes; full drives flag low.
// - Set-full instruction forces full flag low in the accepting device.
// - Slot id writes only in device with full in low, full out high.
// - Software reset sets full flag high, keeps slot id unchanged.
// - With selection active and compare enable high at strobe fall, only slot id equal to select register responds.
// - Select value FFFFH disables comparison; with compare enable high at strobe fall all devices take broadcast writes.
// - With compare enable high at strobe fall, select FFFFH suppresses random and register reads on both read cycles.
// - Global mode still allows associative reads after a detected match.
// - Host selects device by broadcasting slot id; persists until FFFFH.
// - Select register write accepted by every device even in locked chain.
`default_nettype none
module cdec_chain
	import cdec_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Host control pins, active low where named so
	input  wire logic                   cycleStrobe_n,
	input  wire logic                   command_n,
	input  wire logic                   writeEnable_n,
	input  wire logic                   compare_enable_n,
	input  wire logic [CDEC_WORD_W-1:0] dataIn,
	// Chain pins
	input  wire logic                   match_chain_in_n,
	input  wire logic                   full_chain_in_n,
	output logic                        match_flag_out_n,
	output logic                        full_flag_out_n,
	// From the core of the device
	input  wire logic                   localMatch,
	input  wire logic                   matchFlagEnable,
	input  wire logic                   fullFlagEnable,
	input  wire logic                   deviceFull,
	input  wire logic [2:0]             opDecoded,
	input  wire logic                   assocAccess,
	// To the core of the device
	output logic                        cycleStart,
	output logic                        accessGrant,
	output logic                        nextFreeWriteOk,
	output logic                        dataOutEnable_n,
	output logic [CDEC_WORD_W-1:0]      device_select_reg,
	output logic [CDEC_WORD_W-1:0]      chain_slot_id_reg
);
	// Synchronised pins
	logic                   strobeS;
	logic                   cmdS;
	logic                   weS;
	logic                   cmpEnS;
	logic                   miS;
	logic                   fiS;
	logic [CDEC_WORD_W-1:0] dataS;

	cdec_sync #(.W(5)) ctlSync (
		.clk     (clk),
		.rst     (rst),
		.asyncIn ({cycleStrobe_n, command_n, writeEnable_n, compare_enable_n,
			match_chain_in_n}),
		.syncOut ({strobeS, cmdS, weS, cmpEnS, miS})
	);

	cdec_sync #(.W(CDEC_WORD_W + 1)) dataSync (
		.clk     (clk),
		.rst     (rst),
		.asyncIn ({full_chain_in_n, dataIn}),
		.syncOut ({fiS, dataS})
	);

	// Slot match decode, used only for the local-mode grant
	function automatic logic selHit(input logic [15:0] ds, input logic [15:0] slot);
		selHit = (ds == slot);
	endfunction

	// Registered state
	logic                   strobePrev_reg;
	logic                   strobePrev_next;
	logic                   cmpEnCap_reg;
	logic                   cmpEnCap_next;
	logic                   setFull_reg;
	logic                   setFull_next;
	logic [CDEC_WORD_W-1:0] ds_reg;
	logic [CDEC_WORD_W-1:0] ds_next;
	logic [CDEC_WORD_W-1:0] slot_reg;
	logic [CDEC_WORD_W-1:0] slot_next;
	logic                   mf_reg;
	logic                   mf_next;
	logic                   ff_reg;
	logic                   ff_next;
	logic                   grant_reg;
	logic                   grant_next;
	logic                   nfOk_reg;
	logic                   nfOk_next;
	logic                   oe_reg;
	logic                   oe_next;

	cdec_cycle_t cyc;
	cdec_op_t    op;
	logic        startPulse;
	logic        globalMode;
	logic        selected;
	logic        chainWinner;
	logic        slotWriteOk;
	logic        isRead;

	assign cyc        = cdec_cycle_t'({weS, cmdS});
	assign op         = cdec_op_t'(opDecoded);
	assign startPulse = strobePrev_reg & ~strobeS;
	assign globalMode = (ds_reg == CDEC_DS_GLOBAL);
	assign selected   = selHit(ds_reg, slot_reg);
	assign isRead     = (cyc == CDEC_CMD_RD) || (cyc == CDEC_DATA_RD);
	// Highest-priority device: chain input high and an own match
	assign chainWinner = miS & localMatch & matchFlagEnable;
	// Device currently at the head of the free-space chain
	assign slotWriteOk = ~fiS & ff_reg;

	// Command-write decode shared by every register-writing branch
	function automatic logic cmdWriteOf(
		input cdec_cycle_t kind,
		input cdec_op_t    code,
		input cdec_op_t    want
	);
		cmdWriteOf = (kind == CDEC_CMD_WR) && (code == want);
	endfunction

	// Previous strobe level for the edge detector
	always_comb begin
		strobePrev_next = strobeS;
	end

	// Cleared on reset so a strobe already idle high is no false edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strobePrev_reg <= 1'b0;
		end else begin
			strobePrev_reg <= strobePrev_next;
		end
	end

	// Compare enable captured only at a cycle start
	always_comb begin
		cmpEnCap_next = cmpEnCap_reg;
		// Held across idle time so the chain stays locked between cycles
		if (startPulse) begin
			cmpEnCap_next = cmpEnS;
		end
	end

	// Captured compare enable; resets to the flag-forcing level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmpEnCap_reg <= CDEC_CMPEN_RESET;
		end else begin
			cmpEnCap_reg <= cmpEnCap_next;
		end
	end

	// Select, slot id and set-full latch, all written only at cycle start
	always_comb begin
		ds_next      = ds_reg;
		slot_next    = slot_reg;
		setFull_next = setFull_reg;
		if (startPulse) begin
			// Select register write always lands, locked or not
			if (cmdWriteOf(cyc, op, CDEC_OP_WR_DS)) begin
				ds_next = dataS;
			end
			// Slot id is never broadcast: only the free-chain head takes it
			if (cmdWriteOf(cyc, op, CDEC_OP_WR_SLOT) && slotWriteOk) begin
				slot_next = dataS;
			end
			// Set-full hands write eligibility down the chain
			if (cmdWriteOf(cyc, op, CDEC_OP_SETFULL) && slotWriteOk) begin
				setFull_next = 1'b1;
			end
			// Software reset clears set-full but never the slot id
			if (cmdWriteOf(cyc, op, CDEC_OP_SWRESET)) begin
				setFull_next = 1'b0;
			end
		end
	end

	// Configuration registers
	// Only the hardware reset clears the slot id; the command leaves it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ds_reg      <= CDEC_DS_RESET;
			slot_reg    <= CDEC_SLOT_RESET;
			setFull_reg <= 1'b0;
		end else begin
			ds_reg      <= ds_next;
			slot_reg    <= slot_next;
			setFull_reg <= setFull_next;
		end
	end

	// Access decision, taken once per cycle; grant held until the next start, output enable released when the strobe goes high
	always_comb begin
		grant_next = grant_reg;
		oe_next    = oe_reg;
		if (startPulse) begin
			if (~cmpEnS) begin
				// Locked chain: only the highest-priority match answers
				grant_next = chainWinner;
			end else if (globalMode) begin
				// Writes broadcast; reads only where a match picks one device
				grant_next = ~isRead | assocAccess;
			end else begin
				// Local mode: select register must equal own slot id
				grant_next = selected;
			end
			oe_next = ~(grant_next & isRead);
		end else if (strobeS) begin
			// Release the bus between cycles to avoid contention
			oe_next = 1'b1;
		end
	end

	// Access registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			grant_reg <= 1'b0;
			oe_reg    <= 1'b1;
		end else begin
			grant_reg <= grant_next;
			oe_reg    <= oe_next;
		end
	end

	// Match flag computed every clock so the chain ripples freely
	always_comb begin
		if (cmpEnCap_reg) begin
			// Captured disable blocks false edges before local compare settles
			mf_next = 1'b1;
		end else if (~miS) begin
			mf_next = 1'b0;
		end else begin
			mf_next = ~(localMatch & matchFlagEnable);
		end
	end

	// Match flag register; neighbours see a flop, never a glitch
	// Limitation: each device adds three clocks of ripple to the chain (two sync stages plus this flop)
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mf_reg <= 1'b1;
		end else begin
			mf_reg <= mf_next;
		end
	end

	// Full flag and next-free permission from the free-space chain
	always_comb begin
		// Full flag low only with chain input low and device full or forced
		ff_next   = ~(~fiS & ((deviceFull & fullFlagEnable) | setFull_reg));
		// Next-free writes only at the head of the free chain
		nfOk_next = ~fiS & ~deviceFull & ~setFull_reg;
	end

	// Full chain registers; after reset the full flag idles at the not-full level and nfOk_reg is cleared
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ff_reg   <= 1'b1;
			nfOk_reg <= 1'b0;
		end else begin
			ff_reg   <= ff_next;
			nfOk_reg <= nfOk_next;
		end
	end

	// Outputs straight from flops, except cycleStart, which is decoded from two flops
	assign match_flag_out_n  = mf_reg;
	assign full_flag_out_n   = ff_reg;
	assign cycleStart        = startPulse;
	assign accessGrant       = grant_reg;
	assign nextFreeWriteOk   = nfOk_reg;
	assign dataOutEnable_n   = oe_reg;
	assign device_select_reg = ds_reg;
	assign chain_slot_id_reg = slot_reg;
endmodule
`default_nettype wire

// *** verif/cdec_upstream.sv ***
// Upstream neighbour in the chain, driving this device's chain inputs
`default_nettype none
module cdec_upstream (
	// Neighbour state: in the chain, matching, full
	input  wire logic present,
	input  wire logic upMatch,
	input  wire logic upFull,
	// Chain lines toward the device under test
	output logic      matchOut_n,
	output logic      fullOut_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// No neighbour means this is the first device, so the tie-offs apply
	assign matchOut_n = present ? !upMatch : 1'b1;
	assign fullOut_n  = present ? !upFull : 1'b0;
endmodule
`default_nettype wire

// *** verif/cdec_chain_assertions.sv ***
// Port-level checks for the chain block
`default_nettype none
module cdec_chain_assertions
	import cdec_pkg::*;
(
	// Clock, reset and host pins
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic                   cycleStrobe_n,
	input wire logic                   command_n,
	input wire logic                   writeEnable_n,
	input wire logic                   compare_enable_n,
	input wire logic [CDEC_WORD_W-1:0] dataIn,
	// Chain pins and core side
	input wire logic                   match_chain_in_n,
	input wire logic                   full_chain_in_n,
	input wire logic                   match_flag_out_n,
	input wire logic                   full_flag_out_n,
	input wire logic                   localMatch,
	input wire logic                   matchFlagEnable,
	input wire logic                   fullFlagEnable,
	input wire logic                   deviceFull,
	input wire logic [2:0]             opDecoded,
	input wire logic                   assocAccess,
	input wire logic                   cycleStart,
	input wire logic                   dataOutEnable_n,
	input wire logic [CDEC_WORD_W-1:0] device_select_reg,
	input wire logic [CDEC_WORD_W-1:0] chain_slot_id_reg
);
	logic capHigh_reg;
	// Own copy of the captured enable; relies on the pin held across the cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) capHigh_reg <= CDEC_CMPEN_RESET;
		else if (cycleStart) capHigh_reg <= compare_enable_n;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Four cycles cover input sync plus the flag register
	sequence s_above; (!capHigh_reg && !match_chain_in_n)[*4]; endsequence
	sequence s_own; (!capHigh_reg && match_chain_in_n && localMatch && matchFlagEnable)[*4];
	endsequence
	sequence s_wr(o); cycleStart && !command_n && !writeEnable_n && opDecoded == o; endsequence
	force_high_a: assert property (capHigh_reg && $past(capHigh_reg) |-> match_flag_out_n)
		else $error("match flag low while compare disabled");
	chain_force_a: assert property (s_above |-> !match_flag_out_n)
		else $error("match flag not forced by chain input");
	local_match_a: assert property (s_own |-> !match_flag_out_n)
		else $error("local match not flagged");
	no_match_a: assert property ((!capHigh_reg && match_chain_in_n && !localMatch)[*4]
		|-> match_flag_out_n) else $error("match flag low without a match");
	full_low_a: assert property ((!full_chain_in_n && deviceFull && fullFlagEnable)[*4]
		|-> !full_flag_out_n) else $error("full device not flagged");
	full_high_a: assert property (full_chain_in_n[*4] |-> full_flag_out_n)
		else $error("full flag low with space above");
	strobe_fall_a: assert property ($fell(cycleStrobe_n) |-> ##[2:3] cycleStart)
		else $error("cycle start missing");
	start_pulse_a: assert property (cycleStart |=> !cycleStart[*3])
		else $error("cycle start longer than one clock");
	global_read_a: assert property (cycleStart && writeEnable_n && !assocAccess && compare_enable_n &&
		device_select_reg == CDEC_DS_GLOBAL |=> dataOutEnable_n[*3])
		else $error("read driven in global mode");
	ds_write_a: assert property (s_wr(CDEC_OP_WR_DS) |=> device_select_reg == dataIn)
		else $error("select register not written");
	slot_keep_a: assert property (s_wr(CDEC_OP_SWRESET) |=> $stable(chain_slot_id_reg)[*2])
		else $error("slot id changed by reset command");
endmodule
bind cdec_chain cdec_chain_assertions chk_u (.*);
`default_nettype wire

// *** verif/tb_cdec_chain.sv ***
// Self-checking bench for the chain block
`default_nettype none
module tb_cdec_chain
	import cdec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, stb_n = 1'b1, cm_n = 1'b1, we_n = 1'b1, ec_n = 1'b1;
	logic lm = 1'b0, mfEn = 1'b1, ffEn = 1'b1, full = 1'b0, assoc = 1'b0;
	logic present = 1'b0, upM = 1'b0, upF = 1'b0;
	logic [2:0] op = 3'h0;
	logic [15:0] din = 16'h0000, ds, slot;
	logic mIn_n, fIn_n, mf_n, ff_n, start, grant, nfOk, oe_n;
	int mismatches = 0, checks_done = 0;
	initial forever #2.5 clk = ~clk;
	cdec_upstream up_u (.present(present), .upMatch(upM), .upFull(upF),
		.matchOut_n(mIn_n), .fullOut_n(fIn_n));
	cdec_chain dut_u (.clk(clk), .rst(rst), .cycleStrobe_n(stb_n), .command_n(cm_n),
		.writeEnable_n(we_n), .compare_enable_n(ec_n), .dataIn(din),
		.match_chain_in_n(mIn_n), .full_chain_in_n(fIn_n), .match_flag_out_n(mf_n),
		.full_flag_out_n(ff_n), .localMatch(lm), .matchFlagEnable(mfEn),
		.fullFlagEnable(ffEn), .deviceFull(full), .opDecoded(op), .assocAccess(assoc),
		.cycleStart(start), .accessGrant(grant), .nextFreeWriteOk(nfOk),
		.dataOutEnable_n(oe_n), .device_select_reg(ds), .chain_slot_id_reg(slot));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Strobe high gap, then one cycle; returns with strobe still low
	task automatic cyc(input cdec_cycle_t k, input cdec_op_t o, input logic [15:0] d,
		input logic e);
		stb_n = 1'b1;
		repeat (4) @(negedge clk);
		{we_n, cm_n} = k;
		op = o;
		din = d;
		ec_n = e;
		stb_n = 1'b0;
		repeat (6) @(negedge clk);
	endtask
	task automatic idle;
		stb_n = 1'b1;
		repeat (5) @(negedge clk);
	endtask
	// Slot setup through the full chain, then next-free hand-over
	task automatic t_init;
		chk("reset", {12'h000, mf_n, ff_n, oe_n, grant}, 16'h000E);
		cyc(CDEC_CMD_WR, CDEC_OP_WR_DS, 16'h0005, 1'b1);
		chk("ds", ds, 16'h0005);
		cyc(CDEC_CMD_WR, CDEC_OP_WR_SLOT, 16'h0005, 1'b1);
		chk("slot", slot, 16'h0005);
		cyc(CDEC_CMD_WR, CDEC_OP_SETFULL, 16'h0000, 1'b1);
		chk("ff set", 16'(ff_n), 16'h0000);
		cyc(CDEC_CMD_WR, CDEC_OP_WR_SLOT, 16'h0009, 1'b1);
		chk("slot kept", slot, 16'h0005);
		cyc(CDEC_CMD_WR, CDEC_OP_SWRESET, 16'h0000, 1'b1);
		chk("ff reset", {15'h0000, ff_n}, {15'h0000, slot == 16'h0005});
		chk("nf ok", 16'(nfOk), 16'h0001);
		full = 1'b1;
		idle();
		chk("full", {14'h0000, ff_n, nfOk}, 16'h0000);
		present = 1'b1;
		idle();
		chk("above free", {14'h0000, ff_n, nfOk}, 16'h0002);
		present = 1'b0;
		full = 1'b0;
	endtask
	// Local and global selection
	task automatic t_select;
		cyc(CDEC_DATA_RD, CDEC_OP_NONE, 16'h0000, 1'b1);
		chk("sel read", {14'h0000, grant, oe_n}, 16'h0002);
		cyc(CDEC_CMD_WR, CDEC_OP_WR_DS, 16'h0006, 1'b1);
		cyc(CDEC_DATA_RD, CDEC_OP_NONE, 16'h0000, 1'b1);
		chk("other read", {14'h0000, grant, oe_n}, 16'h0001);
		cyc(CDEC_CMD_WR, CDEC_OP_WR_DS, CDEC_DS_GLOBAL, 1'b1);
		cyc(CDEC_DATA_WR, CDEC_OP_NONE, 16'h0000, 1'b1);
		chk("global wr", 16'(grant), 16'h0001);
		cyc(CDEC_DATA_RD, CDEC_OP_NONE, 16'h0000, 1'b1);
		chk("global rd", 16'(oe_n), 16'h0001);
		cyc(CDEC_CMD_RD, CDEC_OP_NONE, 16'h0000, 1'b1);
		chk("global st", 16'(oe_n), 16'h0001);
	endtask
	// Locked chain priority and compare-enable capture
	task automatic t_match;
		present = 1'b1;
		upM = 1'b1;
		cyc(CDEC_DATA_WR, CDEC_OP_NONE, 16'h0000, 1'b0);
		chk("above", {14'h0000, mf_n, grant}, 16'h0000);
		upM = 1'b0;
		lm = 1'b1;
		assoc = 1'b1;
		cyc(CDEC_CMD_RD, CDEC_OP_NONE, 16'h0000, 1'b0);
		chk("winner", {13'h0000, mf_n, grant, oe_n}, 16'h0002);
		mfEn = 1'b0;
		idle();
		chk("mf off", 16'(mf_n), 16'h0001);
		mfEn = 1'b1;
		idle();
		chk("held", 16'(mf_n), 16'h0000);
		cyc(CDEC_DATA_WR, CDEC_OP_NONE, 16'h0000, 1'b1);
		chk("forced", 16'(mf_n), 16'h0001);
	endtask
	// Three-segment comparand load; flags valid only after the last
	task automatic t_comparand;
		cyc(CDEC_DATA_WR, CDEC_OP_NONE, 16'h0001, 1'b1);
		chk("seg one", 16'(mf_n), 16'h0001);
		cyc(CDEC_DATA_WR, CDEC_OP_NONE, 16'h0002, 1'b1);
		chk("seg two", 16'(mf_n), 16'h0001);
		cyc(CDEC_DATA_WR, CDEC_OP_NONE, 16'h0003, 1'b0);
		chk("seg three", 16'(mf_n), 16'h0000);
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		t_init();
		t_select();
		t_match();
		t_comparand();
		give_verdict();
	end
endmodule
`default_nettype wire
